//--- verilog/tic_regs.svh
// Purpose: constants for the timer interrupt and count control block
// Assumes: 32-bit register port, word offsets
// Notes: offsets and layouts below
// Functional notes
// - five event sources merge into one request
// - request high when flag and enable set
// - request drops when no source has both flag and enable set
// - further events leave request unchanged at one
// - flags never cleared by acknowledge
// - clear select clears counter on match A
// - write colliding with clear loads zero
// - counter read after write needs branch
// - status read after write needs branch
// - capture copies counter within one or two clocks
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH
`define TIC_OFS_MODE      8'h00
`define TIC_OFS_CTRL1     8'h04
`define TIC_OFS_CTRL2     8'h08
`define TIC_OFS_ENABLE    8'h0C
`define TIC_OFS_STATUS    8'h10
`define TIC_OFS_COUNTER   8'h14
`define TIC_OFS_GRA       8'h18
`define TIC_OFS_GRB       8'h1C
`define TIC_OFS_GRC       8'h20
`define TIC_OFS_GRD       8'h24
`define TIC_OFS_IRQCTL    8'h28
`define TIC_MODE_START    0
`define TIC_CTRL1_COUNTER_CLEAR_SELECT    7
`define TIC_CTRL1_CKS_LO  4
`define TIC_CTRL2_STOP_ON_MATCH_SELECT    5
`define TIC_NUM_EVT       5
`define TIC_EVT_OVF       4
`define TIC_CNT_CLEAR     16'h0000
`define TIC_CTRL2_RST     8'h18
`endif

//--- verilog/tic_pkg.sv
// Purpose: types for the timer interrupt and count control block
// Assumes: constants come from tic_regs.svh
// Notes: none
`default_nettype none
package tic_pkg;
  typedef logic [15:0] tic_word_t;
  typedef logic [4:0]  tic_evt_t;
endpackage : tic_pkg
`default_nettype wire

//--- verilog/tic_timer.sv
// Purpose: 16-bit timer with compare, capture and merged interrupt request
// Assumes: inputs synchronous to MCLK_IN; count enable is a one-cycle tick
// Notes: capture pins registered once, so edge seen 1-2 clocks late
`include "tic_regs.svh"
`default_nettype none
module tic_timer
  import tic_pkg::*;
(
  input  wire logic        MCLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        CE_IN,
  input  wire logic        COUNT_TICK_IN,
  input  wire logic [3:0]  CAPTURE_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  output logic             IRQ_REQUEST_OUT
);
  logic [7:0]  mode_q;
  logic [7:0]  ctrl1_q;
  logic [7:0]  ctrl2_q;
  tic_evt_t    enable_q;
  tic_evt_t    status_q;
  tic_word_t   counter_q;
  tic_word_t   counter_d;
  tic_word_t   gr_q [4];
  logic [2:0]  irq_prio_q;
  logic [3:0]  cap_s1_q;
  logic [3:0]  cap_s2_q;
  logic        start;
  logic        match_a;
  logic        auto_clr;
  logic        overflow;
  logic [3:0]  cap_edge;
  tic_evt_t    evt_set;
  logic        sel_wr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  assign start    = mode_q[`TIC_MODE_START];
  assign match_a  = start && COUNT_TICK_IN && (counter_q == gr_q[0]);
  assign auto_clr = match_a && ctrl1_q[`TIC_CTRL1_COUNTER_CLEAR_SELECT];
  assign overflow = start && COUNT_TICK_IN && (counter_q == 16'hFFFF) && !auto_clr;
  assign cap_edge = cap_s1_q & ~cap_s2_q;
  assign sel_wr   = WR_IN && CE_IN;

  // events: bits 0..3 match or capture on a..d, bit 4 overflow
  always_comb begin
    evt_set = '0;
    evt_set[0] = match_a | cap_edge[0];
    for (int i = 1; i < 4; i++) begin
      evt_set[i] = (start && COUNT_TICK_IN && counter_q == gr_q[i]) | cap_edge[i];
    end
    evt_set[`TIC_EVT_OVF] = overflow;
  end

  // clear wins over a colliding write and over counting
  always_comb begin
    counter_d = counter_q;
    if (auto_clr) begin
      counter_d = `TIC_CNT_CLEAR;
    end else if (sel_wr && hit(ADDR_IN, `TIC_OFS_COUNTER)) begin
      counter_d = WDATA_IN[15:0];
    end else if (start && COUNT_TICK_IN && !(match_a && ctrl2_q[`TIC_CTRL2_STOP_ON_MATCH_SELECT])) begin
      counter_d = counter_q + 16'h0001;
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      counter_q <= `TIC_CNT_CLEAR;
    end else if (CE_IN) begin
      counter_q <= counter_d;
    end
  end

  // single register stage then edge detect: capture lands 1-2 clocks after pin
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cap_s1_q <= 4'h0;
      cap_s2_q <= 4'h0;
    end else if (CE_IN) begin
      cap_s1_q <= CAPTURE_IN;
      cap_s2_q <= cap_s1_q;
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < 4; i++) begin
        gr_q[i] <= 16'hFFFF;
      end
    end else if (CE_IN) begin
      for (int i = 0; i < 4; i++) begin
        if (cap_edge[i]) begin
          gr_q[i] <= counter_q;
        end else if (sel_wr && hit(ADDR_IN, 8'(`TIC_OFS_GRA + 4 * i))) begin
          gr_q[i] <= WDATA_IN[15:0];
        end
      end
    end
  end

  // stop-on-match clears start; a same-cycle mode write is not guarded
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      mode_q <= 8'h00;
    end else if (CE_IN) begin
      if (sel_wr && hit(ADDR_IN, `TIC_OFS_MODE)) begin
        mode_q <= WDATA_IN[7:0];
      end else if (match_a && ctrl2_q[`TIC_CTRL2_STOP_ON_MATCH_SELECT]) begin
        mode_q[`TIC_MODE_START] <= 1'b0;
      end
    end
  end

  // source select is not locked while counting; software stops first
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl1_q    <= 8'h00;
      ctrl2_q    <= `TIC_CTRL2_RST;
      enable_q   <= '0;
      irq_prio_q <= 3'h0;
    end else if (sel_wr) begin
      if (hit(ADDR_IN, `TIC_OFS_CTRL1)) begin
        ctrl1_q <= WDATA_IN[7:0];
      end else if (hit(ADDR_IN, `TIC_OFS_CTRL2)) begin
        ctrl2_q <= WDATA_IN[7:0] | `TIC_CTRL2_RST;
      end else if (hit(ADDR_IN, `TIC_OFS_ENABLE)) begin
        enable_q <= WDATA_IN[4:0];
      end else if (hit(ADDR_IN, `TIC_OFS_IRQCTL)) begin
        irq_prio_q <= WDATA_IN[2:0];
      end
    end
  end

  // write 0 clears, write 1 keeps; set wins; no clear on acknowledge
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      status_q <= '0;
    end else if (CE_IN) begin
      if (sel_wr && hit(ADDR_IN, `TIC_OFS_STATUS)) begin
        status_q <= (status_q & WDATA_IN[4:0]) | evt_set;
      end else begin
        status_q <= status_q | evt_set;
      end
    end
  end

  // level request, follows flags and enables, not held
  assign IRQ_REQUEST_OUT = |(status_q & enable_q);

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RDATA_OUT <= 32'h0000_0000;
    end else if (CE_IN && RD_IN) begin
      if (hit(ADDR_IN, `TIC_OFS_MODE)) begin
        RDATA_OUT <= {24'h0, mode_q};
      end else if (hit(ADDR_IN, `TIC_OFS_CTRL1)) begin
        RDATA_OUT <= {24'h0, ctrl1_q};
      end else if (hit(ADDR_IN, `TIC_OFS_CTRL2)) begin
        RDATA_OUT <= {24'h0, ctrl2_q};
      end else if (hit(ADDR_IN, `TIC_OFS_ENABLE)) begin
        RDATA_OUT <= {27'h0, enable_q};
      end else if (hit(ADDR_IN, `TIC_OFS_STATUS)) begin
        RDATA_OUT <= {27'h0, status_q};
      end else if (hit(ADDR_IN, `TIC_OFS_COUNTER)) begin
        RDATA_OUT <= {16'h0, counter_q};
      end else if (hit(ADDR_IN, `TIC_OFS_GRA)) begin
        RDATA_OUT <= {16'h0, gr_q[0]};
      end else if (hit(ADDR_IN, `TIC_OFS_GRB)) begin
        RDATA_OUT <= {16'h0, gr_q[1]};
      end else if (hit(ADDR_IN, `TIC_OFS_GRC)) begin
        RDATA_OUT <= {16'h0, gr_q[2]};
      end else if (hit(ADDR_IN, `TIC_OFS_GRD)) begin
        RDATA_OUT <= {16'h0, gr_q[3]};
      end else if (hit(ADDR_IN, `TIC_OFS_IRQCTL)) begin
        RDATA_OUT <= {28'h0, IRQ_REQUEST_OUT, irq_prio_q};
      end else begin
        RDATA_OUT <= 32'h0000_0000;
      end
    end
  end
endmodule : tic_timer
`default_nettype wire

//--- tb/tic_timer_asserts.sv
// Purpose: port-level checks for tic_timer
// Assumes: reads are taken only with CE_IN high
// Notes: request and read-port relations; internal flags are not visible here
`include "tic_regs.svh"
`default_nettype none
module tic_timer_asserts (
  input wire logic        MCLK_IN,
  input wire logic        ARST_N_IN,
  input wire logic        CE_IN,
  input wire logic        COUNT_TICK_IN,
  input wire logic [3:0]  CAPTURE_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        IRQ_REQUEST_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire rd = RD_IN && CE_IN;
  wire en = ADDR_IN == `TIC_OFS_ENABLE;
  a_rdata_hold: assert property (!rd |=> $stable(RDATA_OUT)) else $error("read data moved");
  a_unmapped_zero: assert property (rd && ADDR_IN == 8'h2C |=> RDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  a_irq_holds: assert property (IRQ_REQUEST_OUT && !WR_IN |=> IRQ_REQUEST_OUT)
    else $error("request dropped without a write");
  a_mask_drops: assert property (WR_IN && en && WDATA_IN[4:0] == 5'h0 |=> !IRQ_REQUEST_OUT)
    else $error("request kept with all enables off");
  a_req_visible: assert property (rd && ADDR_IN == `TIC_OFS_IRQCTL |=>
    RDATA_OUT[3] == $past(IRQ_REQUEST_OUT)) else $error("request bit differs from pin");
  a_status_width: assert property (rd && ADDR_IN == `TIC_OFS_STATUS |=>
    RDATA_OUT[31:5] == 27'h0) else $error("status wider than five flags");
  a_ctrl2_fixed: assert property (rd && ADDR_IN == `TIC_OFS_CTRL2 |=> RDATA_OUT[4:3] == 2'h3)
    else $error("fixed control bits not one");
  a_enable_echo: assert property (WR_IN && en ##1 !WR_IN ##1 rd && en |=>
    RDATA_OUT[4:0] == $past(WDATA_IN[4:0], 3)) else $error("enable readback wrong");
endmodule : tic_timer_asserts
bind tic_timer tic_timer_asserts tic_timer_asserts_i (.MCLK_IN, .ARST_N_IN, .CE_IN,
  .COUNT_TICK_IN, .CAPTURE_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT,
  .IRQ_REQUEST_OUT);
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for tic_timer
// Assumes: CE_IN held high so every strobe is taken
// Notes: table rows first, then match, capture and request cases
`include "tic_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {bit w; logic [7:0] a; logic [31:0] d; logic [31:0] x;} tic_row_t;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        tick = 0;
  logic        wr = 0;
  logic        rd = 0;
  logic [3:0]  cap = 4'h0;
  logic [7:0]  ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        irq;
  int          errors = 0;
  int          compares = 0;
  tic_row_t    rows [9] = '{'{0, `TIC_OFS_STATUS, 32'h0, 32'h0},
    '{0, `TIC_OFS_GRD, 32'h0, 32'hFFFF}, '{0, `TIC_OFS_COUNTER, 32'h0, 32'h0},
    '{1, `TIC_OFS_CTRL2, 32'h0, 32'h18}, '{1, `TIC_OFS_GRC, 32'h1234, 32'h1234},
    '{1, 8'h2C, 32'hAB, 32'h0}, '{1, `TIC_OFS_IRQCTL, 32'hF, 32'h7},
    '{1, `TIC_OFS_ENABLE, 32'hFFFF, 32'h1F}, '{1, `TIC_OFS_STATUS, 32'h1F, 32'h0}};
  tic_timer tic_timer_i (.MCLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(1'b1), .COUNT_TICK_IN(tick),
    .CAPTURE_IN(cap), .ADDR_IN(ad), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdat), .IRQ_REQUEST_OUT(irq));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : ck
  // idle edge after each access: a strobe is never set twice in one step
  task automatic wr_t(input logic [7:0] a, input logic [31:0] d, input logic t = 0);
    ad <= a;
    wd <= d;
    wr <= 1;
    tick <= t;
    @(posedge clk);
    wr <= 0;
    tick <= 0;
    @(posedge clk);
  endtask : wr_t
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    ad <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 ck(rdat, e);
    @(posedge clk);
  endtask : rc
  task automatic ci(input logic e);
    #1 ck({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask : ci
  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    #10000;
    errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr_t(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].x);
    end
    $display("table rows done");
    wr_t(`TIC_OFS_CTRL1, 32'h80);
    wr_t(`TIC_OFS_GRA, 32'h5);
    wr_t(`TIC_OFS_COUNTER, 32'h5);
    wr_t(`TIC_OFS_MODE, 32'h1);
    wr_t(`TIC_OFS_COUNTER, 32'h7777, 1'b1);
    rc(`TIC_OFS_COUNTER, 32'h0);
    ci(1'b1);
    wr_t(`TIC_OFS_MODE, 32'h0);
    wr_t(`TIC_OFS_CTRL1, 32'hF0);
    repeat (2) @(posedge clk);
    rc(`TIC_OFS_CTRL1, 32'hF0);
    wr_t(`TIC_OFS_COUNTER, 32'h55);
    cap <= 4'h2;
    repeat (3) @(posedge clk);
    cap <= 4'h0;
    repeat (2) @(posedge clk);
    rc(`TIC_OFS_GRB, 32'h55);
    rc(`TIC_OFS_STATUS, 32'h3);
    ci(1'b1);
    wr_t(`TIC_OFS_STATUS, 32'h1E);
    rc(`TIC_OFS_STATUS, 32'h2);
    wr_t(`TIC_OFS_ENABLE, 32'h0);
    ci(1'b0);
    wr_t(`TIC_OFS_ENABLE, 32'h2);
    ci(1'b1);
    wr_t(`TIC_OFS_STATUS, 32'h0);
    ci(1'b0);
    $display("match capture and request cases done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
